// >>> ipfu_top.v
// Instruction prefetch unit top level
`timescale 1ns/10ps
`default_nettype none
`include "ipfu_defs.vh"
module ipfu_top (
	input wire clk_sys_in,
	input wire rst_in,
	// Register port
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	output reg [31:0] reg_rdata_out,
	// Core instruction request
	input wire core_req_in,
	input wire [1:0] core_kind_in,
	input wire [31:0] core_ptr_in,
	input wire core_ptr_ld_in,
	input wire core_mmove_in,
	input wire core_store_in,
	input wire core_noflush_in,
	input wire core_jump_taken_in,
	output reg core_word_vld_out,
	output reg [31:0] core_word_out,
	output reg core_last_out,
	// Bus master
	output reg bus_req_out,
	output reg [31:0] bus_addr_out,
	output reg [3:0] bus_len_out,
	output reg [3:0] bus_cmd_out,
	input wire bus_gnt_in,
	input wire bus_dvld_in,
	input wire [31:0] bus_data_in,
	input wire bus_done_in
);
	// ****************
	// Registers
	// ****************
	localparam [3:0] CMD_MEM_READ = 4'h6;
	reg [7:0] mode_ff;
	reg [7:0] ctrl_ff;
	reg [31:0] ptr_ff;
	wire [3:0] burst_dw;
	wire burst_ok;
	wire pf_on;
	wire pf_flush_wr;
	wire ptr_wr;
	wire flush;
	// ****************
	// Burst sizing
	// ****************
	ipfu_burst_calc u_calc (
		.burst_len_in(mode_ff[`IPFU_MODE_BL_HI:`IPFU_MODE_BL_LO]),
		.burst_dw_out(burst_dw),
		.burst_ok_out(burst_ok)
	);
	assign pf_on = ctrl_ff[`IPFU_CTRL_PFEN] & burst_ok;
	// ****************
	// Flush sources
	// ****************
	assign pf_flush_wr = reg_wr_in & (reg_addr_in == `IPFU_OFF_CTRL) & reg_wdata_in[`IPFU_CTRL_PFF];
	assign ptr_wr = (reg_wr_in & (reg_addr_in == `IPFU_OFF_PTR)) | core_ptr_ld_in;
	assign flush = ptr_wr
		| ((core_mmove_in | core_store_in) & ~core_noflush_in)
		| core_jump_taken_in
		| pf_flush_wr | ctrl_ff[`IPFU_CTRL_PFF];
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			mode_ff <= `IPFU_MODE_RST;
			ctrl_ff <= `IPFU_CTRL_RST;
		end else begin
			if (reg_wr_in & (reg_addr_in == `IPFU_OFF_MODE)) begin
				mode_ff <= reg_wdata_in[7:0];
			end
			// Flush bit reads back set for one cycle only
			if (reg_wr_in & (reg_addr_in == `IPFU_OFF_CTRL)) begin
				ctrl_ff <= reg_wdata_in[7:0];
			end else begin
				ctrl_ff[`IPFU_CTRL_PFF] <= 1'b0;
			end
		end
	end
	// ****************
	// Fetch state machine
	// ****************
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_BUS = 3'h1;
	localparam [2:0] ST_RD = 3'h2;
	localparam [2:0] ST_OUT = 3'h3;
	localparam [2:0] ST_GAP = 3'h4;
	reg [2:0] st_ff;
	reg [31:0] fetch_addr_ff;
	reg [3:0] got_ff;
	reg [3:0] need_ff;
	reg [3:0] sent_ff;
	reg [3:0] pf_cnt_ff;
	reg [31:0] pf_base_ff;
	reg pf_vld_ff;
	reg [2:0] rd_idx_ff;
	reg rd_pend_ff;
	wire [31:0] mem_q;
	wire pf_hit;
	wire [3:0] pf_end;
	// ****************
	// Instruction sizing
	// ****************
	// Words per instruction and the size of each ownership
	function [3:0] ipfu_words;
		input [1:0] k;
		begin
			case (k)
				2'h1: ipfu_words = 4'h3;
				2'h2: ipfu_words = 4'h3;
				2'h3: ipfu_words = 4'h4;
				default: ipfu_words = 4'h2;
			endcase
		end
	endfunction
	function [3:0] ipfu_chunk;
		input bof;
		input [1:0] k;
		input [3:0] done;
		begin
			if (!bof) begin
				ipfu_chunk = 4'h1;
			end else if (done == 4'h0 || k == 2'h3) begin
				ipfu_chunk = 4'h2;
			end else begin
				ipfu_chunk = 4'h1;
			end
		end
	endfunction
	// ****************
	// Buffer hit and storage
	// ****************
	// Whole instruction must lie inside the valid block
	assign pf_end = {1'b0, ptr_ff[4:2]} + ipfu_words(core_kind_in);
	assign pf_hit = pf_vld_ff & (ptr_ff[31:5] == pf_base_ff[31:5]) & (pf_end <= 4'h8)
		& (pf_cnt_ff == `IPFU_BLOCK_DW);
	ipfu_buf_mem #(.AW(3), .DW(32)) u_mem (
		.clk_sys_in(clk_sys_in),
		.wr_en_in(bus_dvld_in & pf_on & (st_ff == ST_BUS)),
		.wr_addr_in(fetch_addr_ff[4:2]),
		.wr_data_in(bus_data_in),
		.rd_addr_in(rd_idx_ff),
		.rd_data_out(mem_q)
	);
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			st_ff <= ST_IDLE;
			ptr_ff <= 32'h00000000;
			fetch_addr_ff <= 32'h00000000;
			got_ff <= 4'h0;
			need_ff <= 4'h0;
			sent_ff <= 4'h0;
			pf_cnt_ff <= 4'h0;
			pf_base_ff <= 32'h00000000;
			pf_vld_ff <= 1'b0;
			rd_idx_ff <= 3'h0;
			rd_pend_ff <= 1'b0;
			bus_req_out <= 1'b0;
			bus_addr_out <= 32'h00000000;
			bus_len_out <= 4'h0;
			bus_cmd_out <= CMD_MEM_READ;
			core_word_vld_out <= 1'b0;
			core_word_out <= 32'h00000000;
			core_last_out <= 1'b0;
		end else begin
			core_word_vld_out <= 1'b0;
			core_last_out <= 1'b0;
			bus_cmd_out <= CMD_MEM_READ;
			if (reg_wr_in & (reg_addr_in == `IPFU_OFF_PTR)) begin
				ptr_ff <= reg_wdata_in;
			end else if (core_ptr_ld_in) begin
				ptr_ff <= core_ptr_in;
			end
			if (flush | ~pf_on) begin
				pf_vld_ff <= 1'b0;
			end
			case (st_ff)
				ST_IDLE: begin
					if (core_req_in & ~flush) begin
						need_ff <= ipfu_words(core_kind_in);
						sent_ff <= 4'h0;
						if (pf_on & pf_hit) begin
							rd_idx_ff <= ptr_ff[4:2];
							rd_pend_ff <= 1'b1;
							st_ff <= ST_OUT;
						end else if (pf_on) begin
							fetch_addr_ff <= {ptr_ff[31:5], 5'h00};
							pf_base_ff <= {ptr_ff[31:5], 5'h00};
							pf_cnt_ff <= 4'h0;
							bus_addr_out <= {ptr_ff[31:5], 5'h00};
							bus_len_out <= burst_dw;
							bus_req_out <= 1'b1;
							got_ff <= 4'h0;
							st_ff <= ST_BUS;
						end else begin
							fetch_addr_ff <= ptr_ff;
							bus_addr_out <= ptr_ff;
							bus_len_out <= ipfu_chunk(mode_ff[`IPFU_MODE_BOF], core_kind_in, 4'h0);
							bus_req_out <= 1'b1;
							got_ff <= 4'h0;
							st_ff <= ST_BUS;
						end
					end
				end
				ST_BUS: begin
					if (bus_gnt_in) begin
						bus_req_out <= 1'b0;
					end
					if (bus_dvld_in) begin
						fetch_addr_ff <= fetch_addr_ff + 32'h00000004;
						if (pf_on) begin
							pf_cnt_ff <= pf_cnt_ff + 4'h1;
						end else begin
							core_word_vld_out <= 1'b1;
							core_word_out <= bus_data_in;
							core_last_out <= (got_ff + 4'h1 == need_ff);
							got_ff <= got_ff + 4'h1;
						end
					end
					if (bus_done_in) begin
						if (pf_on) begin
							if (pf_cnt_ff + {3'h0, bus_dvld_in} >= `IPFU_BLOCK_DW) begin
								pf_vld_ff <= ~flush;
								st_ff <= ST_IDLE;
							end else begin
								// Ask again for the rest of the block
								bus_addr_out <= fetch_addr_ff + {29'h0, bus_dvld_in, 2'h0};
								bus_req_out <= 1'b1;
							end
						end else if (got_ff + {3'h0, bus_dvld_in} >= need_ff) begin
							ptr_ff <= fetch_addr_ff + {29'h0, bus_dvld_in, 2'h0};
							st_ff <= ST_IDLE;
						end else begin
							st_ff <= ST_GAP;
						end
					end
				end
				ST_GAP: begin
					bus_addr_out <= fetch_addr_ff;
					bus_len_out <= ipfu_chunk(mode_ff[`IPFU_MODE_BOF], core_kind_in, got_ff);
					bus_req_out <= 1'b1;
					st_ff <= ST_BUS;
				end
				ST_OUT: begin
					if (rd_pend_ff) begin
						// Read data trail the index by one cycle
						rd_pend_ff <= 1'b0;
						rd_idx_ff <= rd_idx_ff + 3'h1;
					end else begin
						// Index already points at the next word
						core_word_vld_out <= 1'b1;
						core_word_out <= mem_q;
						core_last_out <= (sent_ff + 4'h1 == need_ff);
						sent_ff <= sent_ff + 4'h1;
						rd_pend_ff <= 1'b1;
						if (sent_ff + 4'h1 == need_ff) begin
							ptr_ff <= ptr_ff + {26'h0, need_ff, 2'h0};
							rd_pend_ff <= 1'b0;
							st_ff <= ST_IDLE;
						end
					end
				end
				default: st_ff <= ST_IDLE;
			endcase
		end
	end
	// ****************
	// Register read
	// ****************
	always @(posedge clk_sys_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 32'h00000000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`IPFU_OFF_MODE: reg_rdata_out <= {24'h0, mode_ff};
				`IPFU_OFF_CTRL: reg_rdata_out <= {24'h0, ctrl_ff};
				`IPFU_OFF_PTR: reg_rdata_out <= ptr_ff;
				`IPFU_OFF_STAT: reg_rdata_out <= {20'h0, pf_cnt_ff, 1'b0, st_ff, pf_on, pf_vld_ff, burst_ok, 1'b0};
				default: reg_rdata_out <= 32'h00000000;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> ipfu_defs.vh
// Constants for the instruction prefetch unit
`ifndef IPFU_DEFS_VH
`define IPFU_DEFS_VH
// Register offsets
`define IPFU_OFF_MODE 8'h38
`define IPFU_OFF_CTRL 8'h3B
`define IPFU_OFF_PTR 8'h2C
`define IPFU_OFF_STAT 8'h40
// dma_mode_control fields
`define IPFU_MODE_BL_HI 7
`define IPFU_MODE_BL_LO 6
`define IPFU_MODE_BOF 1
`define IPFU_MODE_RST 8'h00
// dma_control_reg fields
`define IPFU_CTRL_PFEN 5
`define IPFU_CTRL_PFF 6
`define IPFU_CTRL_RST 8'h00
// Prefetch block and minimum burst, in dwords
`define IPFU_BLOCK_DW 4'h8
`define IPFU_MIN_BURST 4'h4
`endif

// >>> ipfu_buf_mem.v
// Prefetch word store with registered read data
`timescale 1ns/10ps
`default_nettype none
module ipfu_buf_mem #(
	parameter AW = 3,
	parameter DW = 32
) (
	input wire clk_sys_in,
	input wire wr_en_in,
	input wire [AW-1:0] wr_addr_in,
	input wire [DW-1:0] wr_data_in,
	input wire [AW-1:0] rd_addr_in,
	output reg [DW-1:0] rd_data_out
);
	reg [DW-1:0] mem [0:(1<<AW)-1];
	always @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end
endmodule
`default_nettype wire

// >>> ipfu_burst_calc.v
// Burst size derivation from the burst length field
`timescale 1ns/10ps
`default_nettype none
`include "ipfu_defs.vh"
module ipfu_burst_calc (
	input wire [1:0] burst_len_in,
	output wire [3:0] burst_dw_out,
	output wire burst_ok_out
);
	// Field 0..3 selects 2,4,8,16 dwords; capped at one block
	function [3:0] ipfu_burst;
		input [1:0] bl;
		begin
			case (bl)
				2'h0: ipfu_burst = 4'h2;
				2'h1: ipfu_burst = 4'h4;
				default: ipfu_burst = `IPFU_BLOCK_DW;
			endcase
		end
	endfunction
	assign burst_dw_out = ipfu_burst(burst_len_in);
	assign burst_ok_out = (ipfu_burst(burst_len_in) >= `IPFU_MIN_BURST);
endmodule
`default_nettype wire

// >>> ipfu_host_mem.sv
// Host memory model serving the unit's bus requests
`timescale 1ns/10ps
`default_nettype none
module ipfu_host_mem (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic slow_in,
	input wire logic req_in,
	input wire logic [31:0] addr_in,
	input wire logic [3:0] len_in,
	output logic gnt_out,
	output logic dvld_out,
	output logic [31:0] data_out,
	output logic done_out
);
logic [3:0] left_ff;
logic [31:0] a_ff;
logic [1:0] wait_ff;
// ********
// Grant, then one word a cycle
// ********
always @(posedge clk_sys_in or posedge rst_in) begin
	if (rst_in) begin
		{gnt_out, dvld_out, done_out, left_ff, wait_ff} <= 9'h000;
		data_out <= 32'h0;
		a_ff <= 32'h0;
	end else begin
		gnt_out <= 1'b0;
		dvld_out <= 1'b0;
		done_out <= 1'b0;
		// Idle data toggles so stale words never pass
		data_out <= ~data_out;
		if (left_ff != 4'h0) begin
			dvld_out <= 1'b1;
			data_out <= a_ff ^ 32'hA5A50000;
			a_ff <= a_ff + 32'h4;
			left_ff <= left_ff - 4'h1;
			done_out <= left_ff == 4'h1;
		end else if (req_in && !gnt_out) begin
			if (wait_ff >= {slow_in, slow_in}) begin
				gnt_out <= 1'b1;
				a_ff <= addr_in;
				left_ff <= len_in;
				wait_ff <= 2'h0;
			end else begin
				wait_ff <= wait_ff + 2'h1;
			end
		end
	end
end
endmodule
`default_nettype wire

// >>> ipfu_top_checker.sv
// Port assertions for the prefetch unit
`timescale 1ns/10ps
`default_nettype none
module ipfu_top_checker (
	input wire clk_sys_in,
	input wire rst_in,
	input wire [7:0] reg_addr_in,
	input wire [31:0] reg_wdata_in,
	input wire reg_wr_in,
	input wire reg_rd_in,
	input wire [31:0] reg_rdata_out,
	input wire core_word_vld_out,
	input wire [31:0] core_word_out,
	input wire core_last_out,
	input wire bus_req_out,
	input wire [3:0] bus_len_out,
	input wire [3:0] bus_cmd_out,
	input wire bus_gnt_in,
	input wire bus_dvld_in,
	input wire [31:0] bus_data_in
);
reg pf_ff;
reg bof_ff;
reg [1:0] bl_ff;
wire single = !bof_ff && (!pf_ff || bl_ff == 2'h0);
default clocking @(posedge clk_sys_in); endclocking
default disable iff (rst_in);
// ********
// Mode mirror and checks
// ********
always @(posedge clk_sys_in or posedge rst_in) begin
	if (rst_in) begin
		pf_ff <= 1'b0;
		bof_ff <= 1'b0;
		bl_ff <= 2'h0;
	end else begin
		if (reg_wr_in && reg_addr_in == 8'h3B) pf_ff <= reg_wdata_in[5];
		if (reg_wr_in && reg_addr_in == 8'h38) begin
			bl_ff <= reg_wdata_in[7:6];
			bof_ff <= reg_wdata_in[1];
		end
	end
end
a_cmd_plain: assert property (bus_cmd_out == 4'h6) else $error("bus command not plain read");
a_req_hold: assert property (bus_req_out && !bus_gnt_in |=> bus_req_out) else $error("request dropped");
a_pf_len: assert property (pf_ff && bl_ff != 2'h0 && bus_req_out
	|-> bus_len_out == (bl_ff == 2'h1 ? 4'h4 : 4'h8)) else $error("prefetch burst length wrong");
a_single_len: assert property (single && bus_req_out |-> bus_len_out == 4'h1) else $error("single length wrong");
a_bof_len: assert property (bof_ff && !pf_ff && bus_req_out
	|-> bus_len_out inside {4'h1, 4'h2}) else $error("opcode burst length wrong");
a_word_pass: assert property (bus_dvld_in && (single || !pf_ff)
	|=> core_word_vld_out && core_word_out == $past(bus_data_in)) else $error("word not forwarded");
a_last_word: assert property (core_last_out |-> core_word_vld_out) else $error("last without word");
a_rd_unmap: assert property (reg_rd_in && !(reg_addr_in inside {8'h38, 8'h3B, 8'h2C, 8'h40})
	|=> reg_rdata_out == 32'h0) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// >>> ipfu_top_tb.sv
// Self-checking bench for the prefetch unit
`timescale 1ns/10ps
`default_nettype none
module ipfu_top_tb;
logic clk_sys_in = 0, rst_in = 1, slow = 0, reg_wr_in = 0, reg_rd_in = 0, core_req_in = 0;
logic core_ptr_ld_in = 0, core_mmove_in = 0, core_store_in = 0, core_noflush_in = 0, core_jump_taken_in = 0;
logic [7:0] reg_addr_in = 0;
logic [1:0] core_kind_in = 0;
logic [31:0] reg_wdata_in = 0, core_ptr_in = 32'h100, reg_rdata_out, core_word_out, bus_addr_out, bus_data_in;
logic core_word_vld_out, core_last_out, bus_req_out, bus_gnt_in, bus_dvld_in, bus_done_in;
logic [3:0] bus_len_out, bus_cmd_out;
logic [4:0] pat [8] = '{5'h00, 5'h14, 5'h0C, 5'h10, 5'h00, 5'h08, 5'h02, 5'h01};
int ow [8] = '{1, 0, 0, 1, 1, 1, 1, 1};
int err_count = 0, num_checks = 0, gc = 0, k;
always #20 clk_sys_in = ~clk_sys_in;
always @(posedge clk_sys_in) if (bus_gnt_in) gc <= gc + 1;
ipfu_top uut (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
	.core_req_in, .core_kind_in, .core_ptr_in, .core_ptr_ld_in, .core_mmove_in, .core_store_in,
	.core_noflush_in, .core_jump_taken_in, .core_word_vld_out, .core_word_out, .core_last_out, .bus_req_out,
	.bus_addr_out, .bus_len_out, .bus_cmd_out, .bus_gnt_in, .bus_dvld_in, .bus_data_in, .bus_done_in);
ipfu_host_mem mem (.clk_sys_in, .rst_in, .slow_in(slow), .req_in(bus_req_out), .addr_in(bus_addr_out),
	.len_in(bus_len_out), .gnt_out(bus_gnt_in), .dvld_out(bus_dvld_in), .data_out(bus_data_in), .done_out(bus_done_in));
// ********
// Access tasks
// ********
task chk(input [31:0] s, input [31:0] e, input string nm);
	num_checks++;
	if (s !== e) begin
		err_count++;
		$display("[ERR] %s exp %h got %h", nm, e, s);
	end
endtask
task wr_r(input [7:0] a, input [31:0] d);
	@(posedge clk_sys_in) {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'b1};
	@(posedge clk_sys_in) reg_wr_in <= 0;
endtask
task rd_r(input [7:0] a, input [31:0] e);
	@(posedge clk_sys_in) {reg_addr_in, reg_rd_in} <= {a, 1'b1};
	@(posedge clk_sys_in) reg_rd_in <= 0;
	@(negedge clk_sys_in) chk(reg_rdata_out, e, "reg");
endtask
task ev(input [4:0] p);
	@(posedge clk_sys_in) {core_mmove_in, core_store_in, core_noflush_in, core_jump_taken_in, core_ptr_ld_in} <= p;
	@(posedge clk_sys_in) {core_mmove_in, core_store_in, core_noflush_in, core_jump_taken_in, core_ptr_ld_in} <= 0;
endtask
task fetch(input [1:0] kd, input int ns);
	int i, t, g, n;
	i = 0;
	t = 0;
	g = gc;
	n = kd == 0 ? 2 : kd == 3 ? 4 : 3;
	@(posedge clk_sys_in) {core_kind_in, core_req_in} <= {kd, 1'b1};
	do begin
		@(negedge clk_sys_in) t++;
		if (core_word_vld_out === 1'b1) begin
			chk(core_word_out, (core_ptr_in + 4 * i) ^ 32'hA5A50000, "word");
			i++;
			// Request low before the unit idles, else it is taken again
			if (i == n - 1) @(posedge clk_sys_in) core_req_in <= 0;
		end
	end while (core_last_out !== 1'b1 && t < 300);
	chk(i, n, "count");
	chk(gc - g, ns, "owns");
	@(posedge clk_sys_in) core_req_in <= 0;
	core_ptr_in <= core_ptr_in + 4 * i;
	@(negedge clk_sys_in);
endtask
task conclude;
	if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
	else $display("*** FAIL ***");
	$finish;
endtask
initial begin
	repeat (20000) @(posedge clk_sys_in);
	err_count++;
	conclude;
end
initial begin
	repeat (3) @(posedge clk_sys_in);
	rst_in <= 0;
	rd_r(8'h38, 0);
	rd_r(8'h3B, 0);
	wr_r(8'h10, 32'hFF);
	rd_r(8'h10, 0);
	wr_r(8'h2C, core_ptr_in);
	rd_r(8'h2C, core_ptr_in);
	for (k = 0; k < 4; k++) fetch(k[1:0], k == 0 ? 2 : k == 3 ? 4 : 3);
	wr_r(8'h38, 32'h02);
	slow <= 1;
	for (k = 0; k < 4; k++) fetch(k[1:0], k == 0 ? 1 : 2);
	wr_r(8'h38, 32'h80);
	wr_r(8'h3B, 32'h20);
	for (k = 0; k < 8; k++) begin
		ev(pat[k]);
		fetch(0, ow[k]);
	end
	fetch(0, 1);
	wr_r(8'h3B, 32'h60);
	rd_r(8'h3B, 32'h20);
	fetch(0, 1);
	rd_r(8'h2C, core_ptr_in);
	wr_r(8'h38, 32'h40);
	wr_r(8'h2C, core_ptr_in);
	fetch(0, 2);
	rd_r(8'h40, 32'h80E);
	wr_r(8'h38, 32'h00);
	wr_r(8'h2C, core_ptr_in);
	fetch(0, 2);
	rd_r(8'h40, 32'h800);
	conclude;
end
endmodule
bind ipfu_top ipfu_top_checker chk_i (.clk_sys_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .core_word_vld_out, .core_word_out, .core_last_out, .bus_req_out, .bus_len_out,
	.bus_cmd_out, .bus_gnt_in, .bus_dvld_in, .bus_data_in);
`default_nettype wire
